// ---- logic/eod_decoder.v ----
// AHB-Lite opcode field decoder for the escape-class numeric instructions
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "eod_regs.vh"

// How it works
// - Start only opcodes with escape prefix 11011
// - Addressing fields read as host CPU does
// - Memory operands use host addressing modes
// - Displacement count follows addressing kind, base
// - Target bit zero makes stack top destination
// - Swap xor target fixes operand order
// - Subtract/divide low opcode bit is swap
// - Release flag one pops stack afterwards
// - Slot index counts down from stack top
// - Base plus index adds one clock
// - Clock count includes host transfer time
// - Status word read through status port
// - Execution waits for pointer port write
module eod_decoder (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	output wire exec_start,
	output wire pop_after
);

	reg wr_pend_ff;
	reg [7:0] addr_ff;
	reg [31:0] rdata_ff;
	reg [15:0] opcode_ff;
	reg [15:0] status_ff;
	reg [15:0] offset_bytes_ff;
	reg [1:0] offset_bytes_cnt_ff;
	reg [7:0] clocks_ff;
	reg [7:0] clk_base_ff;
	reg valid_ff;
	reg armed_ff;
	reg start_ff;
	reg pop_ff;

	wire take;
	wire wr_opcode;
	wire wr_offset_bytes;
	wire wr_pointer;
	wire wr_ctrl;
	wire fire;
	reg [31:0] nxt_rdata;
	reg [15:0] nxt_offset_bytes;
	reg [1:0] nxt_offset_bytes_cnt;
	reg [7:0] nxt_clocks;

	// Escape prefix test, used on the stored and the incoming opcode
	function is_escape;
		input [4:0] hi;
		begin
			is_escape = (hi == `EOD_PREFIX);
		end
	endfunction

	// Displacement bytes implied by addressing kind and base selector
	function [1:0] offset_bytes_len;
		input [1:0] kind;
		input [2:0] rm;
		begin
			case (kind)
				2'h0: offset_bytes_len = (rm == 3'h6) ? 2'h2 : 2'h0;
				2'h1: offset_bytes_len = 2'h1;
				2'h2: offset_bytes_len = 2'h2;
				default: offset_bytes_len = 2'h0;
			endcase
		end
	endfunction

	// Base plus index forms of the host encoding: r/m 000..011, memory kind
	function both_regs;
		input [1:0] kind;
		input [2:0] rm;
		begin
			both_regs = (kind != `EOD_MOD_REG) && (rm[2] == 1'b0);
		end
	endfunction

	// Opcode fields: byte 0 in [15:8], byte 1 in [7:0]
	wire [15:0] op = opcode_ff;
	wire is_esc = is_escape(op[15:11]);
	wire [1:0] kind = op[7:6];
	wire [2:0] rm = op[2:0];
	wire reg_form = (kind == `EOD_MOD_REG);
	wire [1:0] mf = op[10:9];
	wire tgt = op[10];
	wire pop_bit = op[9];
	wire [2:0] opcode_part_two = op[5:3];
	wire arith = reg_form && (op[8] == 1'b0);
	wire subdiv = (opcode_part_two[2:1] == 2'h2) || (opcode_part_two[2:1] == 2'h3);
	wire swap = subdiv ? opcode_part_two[0] : 1'b0;
	wire [2:0] subop = subdiv ? {opcode_part_two[2:1], 1'b0} : opcode_part_two;
	wire dest_slot = reg_form & tgt;
	wire rev_order = arith & (swap ^ tgt);
	wire [1:0] ndisp = offset_bytes_len(kind, rm);
	wire extra = both_regs(kind, rm);

	// Status word: prefix ok, reg form, dest, order, pop, offset_bytes, type
	wire [15:0] nxt_status = {is_esc, reg_form, dest_slot, rev_order,
		reg_form & pop_bit, ndisp, mf, subop, rm, extra};

	assign take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;
	assign exec_start = start_ff;
	assign pop_after = pop_ff;

	// Write strobes act in the data phase, when hwdata stands
	assign wr_opcode = wr_pend_ff && (addr_ff == `EOD_OFS_OPCODE);
	assign wr_offset_bytes = wr_pend_ff && (addr_ff == `EOD_OFS_OFFSET_BYTES);
	assign wr_pointer = wr_pend_ff && (addr_ff == `EOD_OFS_POINTER);
	assign wr_ctrl = wr_pend_ff && (addr_ff == `EOD_OFS_CTRL);
	assign fire = wr_pointer && armed_ff;

	always @*
	begin
		case (haddr[7:0])
			`EOD_OFS_STATUS: nxt_rdata = {16'h0000, status_ff};
			`EOD_OFS_OPCODE: nxt_rdata = {16'h0000, opcode_ff};
			`EOD_OFS_CTRL: nxt_rdata = {24'h000000, clk_base_ff};
			`EOD_OFS_DECODE: nxt_rdata = {29'h0, armed_ff, valid_ff,
				ndisp != 2'h0};
			`EOD_OFS_CLOCKS: nxt_rdata = {24'h000000, clocks_ff};
			`EOD_OFS_OFFSET_BYTES: nxt_rdata = {14'h0, offset_bytes_cnt_ff, offset_bytes_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Count in device clocks, transfer time included
	always @*
	begin
		if (extra)
			nxt_clocks = clk_base_ff + `EOD_EXTRA_CLOCK;
		else
			nxt_clocks = clk_base_ff;
	end

	// Extra displacement writes beyond the decoded length are dropped
	always @*
	begin
		nxt_offset_bytes = offset_bytes_ff;
		nxt_offset_bytes_cnt = offset_bytes_cnt_ff;
		if (offset_bytes_cnt_ff < ndisp)
		begin
			if (offset_bytes_cnt_ff == 2'h0)
				nxt_offset_bytes = {8'h00, hwdata[7:0]};
			else
				nxt_offset_bytes = {hwdata[7:0], offset_bytes_ff[7:0]};
			nxt_offset_bytes_cnt = offset_bytes_cnt_ff + 2'h1;
		end
	end

	// Address phase capture
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= take & hwrite;
			if (take)
				addr_ff <= haddr[7:0];
		end
	end

	// Read data is taken at the address edge so it stands in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata_ff <= 32'h00000000;
		else if (take & ~hwrite)
			rdata_ff <= nxt_rdata;
	end

	// Accepted even while a prior opcode waits
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			opcode_ff <= 16'h0000;
			valid_ff <= 1'b0;
		end
		else if (wr_opcode)
		begin
			opcode_ff <= hwdata[15:0];
			valid_ff <= 1'b1;
		end
	end

	// Only escape-class opcodes arm the start; a new opcode re-arms
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			armed_ff <= 1'b0;
		else if (wr_opcode)
			armed_ff <= is_escape(hwdata[15:11]);
		else if (fire)
			armed_ff <= 1'b0;
	end

	// Status lags the opcode by one cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_ff <= `EOD_STATUS_RST;
		else if (valid_ff)
			status_ff <= nxt_status;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clocks_ff <= 8'h00;
		else if (valid_ff)
			clocks_ff <= nxt_clocks;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clk_base_ff <= `EOD_BASE_CLOCKS;
		else if (wr_ctrl)
			clk_base_ff <= hwdata[7:0];
	end

	// A new opcode discards any displacement of the previous one
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			offset_bytes_ff <= 16'h0000;
			offset_bytes_cnt_ff <= 2'h0;
		end
		else if (wr_opcode)
		begin
			offset_bytes_ff <= 16'h0000;
			offset_bytes_cnt_ff <= 2'h0;
		end
		else if (wr_offset_bytes)
		begin
			offset_bytes_ff <= nxt_offset_bytes;
			offset_bytes_cnt_ff <= nxt_offset_bytes_cnt;
		end
	end

	// Start pulse lasts one cycle; non-escape opcodes never start
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			start_ff <= 1'b0;
		else
			start_ff <= fire;
	end

	// Pop level holds until the next started instruction
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pop_ff <= 1'b0;
		else if (fire)
			pop_ff <= reg_form & pop_bit;
	end

endmodule // eod_decoder

// ---- logic/eod_regs.vh ----
// Register offsets, field positions and timing counts of the opcode decoder
`ifndef EOD_REGS_VH
`define EOD_REGS_VH
`define EOD_OFS_OPCODE 8'hf8
`define EOD_OFS_OPERAND 8'hfa
`define EOD_OFS_POINTER 8'hfc
`define EOD_OFS_STATUS 8'hfe
`define EOD_OFS_CTRL 8'h00
`define EOD_OFS_DECODE 8'h04
`define EOD_OFS_CLOCKS 8'h08
`define EOD_OFS_OFFSET_BYTES 8'h0c
`define EOD_PREFIX 5'h1b
`define EOD_MOD_REG 2'h3
`define EOD_CTRL_RST 32'h00000000
`define EOD_STATUS_RST 16'h0000
`define EOD_BASE_CLOCKS 8'h10
`define EOD_EXTRA_CLOCK 8'h01
`define EOD_MF_REAL32 2'h0
`define EOD_MF_INT32 2'h1
`define EOD_MF_REAL64 2'h2
`define EOD_MF_INT16 2'h3
`endif

// ---- testbench/eod_chk_sva.sv ----
// Assertions on the decoder's bus and start-pulse ports
`timescale 1ns/1ps
module eod_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire exec_start,
	input wire pop_after
);
	wire rd = hsel && htrans[1] && !hwrite;
	wire pw = hsel && htrans[1] && hwrite && haddr[7:0] == 8'hfc;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rdy; hreadyout; endproperty
	a_rdy: assert property (p_rdy) else $error("stall");
	property p_ok; !hresp; endproperty
	a_ok: assert property (p_ok) else $error("resp");
	property p_one; exec_start |=> !exec_start; endproperty
	a_one: assert property (p_one) else $error("long");
	property p_go; exec_start |-> $past(pw, 2); endproperty
	a_go: assert property (p_go) else $error("start");
	property p_pop; !$stable(pop_after) |-> exec_start; endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_hold; !$past(rd) |-> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_hi; rd && haddr[7:0] == 8'hfe |=> !hrdata[31:16]; endproperty
	a_hi: assert property (p_hi) else $error("wide");
	property p_map; rd && haddr[7:0] == 8'h40 |=> !hrdata; endproperty
	a_map: assert property (p_map) else $error("map");
endmodule // eod_chk
bind eod_decoder eod_chk u_chk (.*);

// ---- testbench/eod_host.sv ----
// Host model handing opcodes over AHB-Lite
`timescale 1ns/1ps
module eod_host (
	input wire hclk,
	input wire hready,
	input wire [31:0] hrdata,
	output reg hsel = 1'b1,
	output reg [31:0] haddr = 32'h0,
	output reg [1:0] htrans = 2'h0,
	output reg hwrite = 1'b0,
	output reg [2:0] hsize = 3'h2,
	output reg [31:0] hwdata = 32'h0
);
	// No busy test first: opcode and pointer writes are legal any time
	task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (!hready);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hready);
		q = hrdata;
	endtask
endmodule // eod_host

// ---- testbench/tb.sv ----
// Random opcodes checked against a field model
`timescale 1ns/1ps
`include "eod_regs.vh"
module tb;
	reg hclk = 0, hresetn = 0;
	wire hsel, hwrite, hreadyout, hresp, exec_start, pop_after;
	wire [1:0] htrans;
	wire [2:0] hsize;
	wire [31:0] haddr, hwdata, hrdata;
	integer error_cnt = 0, num_checks = 0, seed = 38437, sc = 0, n = 0, i;
	reg [31:0] r;
	reg [15:0] o, e, m, b;
	reg [1:0] d;
	reg g;
	eod_host host (.hready(hreadyout), .*);
	eod_decoder DUT (.hready(hreadyout), .*);
	initial forever #5 hclk = ~hclk;
	always @(posedge hclk) sc <= sc + exec_start;
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#100000;
		error_cnt = error_cnt + 1;
		results;
	end
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		host.xfer(0, 8'h40, 0, r);
		chk(r, 0);
		for (i = 0; i < 48; i = i + 1)
		begin
			o = $random(seed);
			if (i % 4)
				o[15:11] = 5'h1b;
			g = o[7:6] == 2'h3;
			d = o[7:6] == 2'h1 ? 2'h1 : (o[7:6] == 2'h2 ||
				{o[7:6], o[2:0]} == 5'h06) ? 2'h2 : 2'h0;
			e = {o[15:11] == 5'h1b, g, g & o[10],
				g & !o[8] & ((o[5] & o[3]) ^ o[10]), g & o[9], d,
				o[10:9], o[5:4], o[3] & !o[5], o[2:0], !g && !o[2]};
			m = e[15] ? (g ? 16'hfe7f : 16'hffff) : 16'h8000;
			host.xfer(1, 8'hf8, {16'h0, o}, r);
			// Status settles a cycle late, so one idle cycle first
			@(posedge hclk);
			host.xfer(0, 8'hfe, 0, r);
			chk(r & m, e & m);
			host.xfer(0, 8'h08, 0, r);
			chk(r, `EOD_BASE_CLOCKS + e[0]);
			b = $random(seed);
			host.xfer(1, 8'h0c, {24'h0, b[7:0]}, r);
			host.xfer(1, 8'h0c, {24'h0, b[15:8]}, r);
			host.xfer(0, 8'h0c, 0, r);
			chk(r, {14'h0, d, d == 2'h2 ? b :
				{8'h0, b[7:0] & {8{d[0]}}}});
			chk(sc, n);
			n = n + e[15];
			host.xfer(1, 8'hfc, 0, r);
			repeat (3) @(posedge hclk);
			chk(sc, n);
			if (e[15])
				chk(pop_after, g & o[9]);
		end
		host.xfer(1, 8'hfc, 0, r);
		repeat (3) @(posedge hclk);
		chk(sc, n);
		results;
	end
endmodule // tb
